/* File: common/pms_pkg.sv */
// shared constants and types of the power mode sequencer
package pms_pkg;
  localparam logic [7:0]  PMS_OFF_CTRL    = 8'h00;
  localparam logic [7:0]  PMS_OFF_WK_LO   = 8'h04;
  localparam logic [7:0]  PMS_OFF_WK_HI   = 8'h08;
  localparam logic [7:0]  PMS_OFF_REST    = 8'h0C;
  localparam logic [7:0]  PMS_OFF_RISE1   = 8'h10;
  localparam int          PMS_B_USB_UP    = 9;
  localparam int          PMS_B_USB_DOWN  = 8;
  localparam int          PMS_B_POR_LVL   = 7;
  localparam int          PMS_B_REAPPLY   = 6;
  localparam int          PMS_B_WIDE      = 5;
  localparam int          PMS_B_TMR_EN    = 4;
  localparam int          PMS_B_PIN_LVL   = 3;
  localparam int          PMS_B_PIN_EN    = 2;
  localparam int          PMS_B_SLEEP     = 1;
  localparam int          PMS_B_CLK_DEF   = 0;
  localparam int          PMS_F_DWELL     = 16;
  localparam int          PMS_F_GATE      = 14;
  localparam int          PMS_F_APFM      = 9;
  localparam int          PMS_F_CPFM      = 8;
  localparam int          PMS_F_IO        = 5;
  localparam int          PMS_F_PLL       = 4;
  localparam int          PMS_F_AEN       = 1;
  localparam int          PMS_F_CEN       = 0;
  localparam logic [31:0] PMS_CTRL_RESET  = 32'h0000_0008;
  localparam logic [31:0] PMS_CTRL_WMASK  = 32'h0000_03BD;
  localparam logic [31:0] PMS_WORD_WMASK  = 32'h001F_4331;
  localparam logic [31:0] PMS_REST_RESET  = 32'h0010_0000;
  localparam logic [31:0] PMS_RISE1_RESET = 32'h0010_0020;
  localparam logic [31:0] PMS_WAKE_RESET  = 32'h0000_0000;

  typedef enum logic [2:0] {
    PMS_RUN   = 3'b000,
    PMS_DESC1 = 3'b001,
    PMS_DESC2 = 3'b010,
    PMS_REST  = 3'b011,
    PMS_RISE1 = 3'b100,
    PMS_RISE2 = 3'b101
  } pms_state_e;

  typedef struct packed {
    logic clk_gate;
    logic analogue_pfm;
    logic core_pfm;
    logic io_en;
    logic pll_en;
    logic analogue_en;
    logic core_en;
  } pms_supply_s;

  typedef struct packed {
    logic io;
    logic pll;
    logic analogue;
    logic core;
  } pms_good_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } pms_req_s;

  // run-state supplies after reset: all four supplies on, pwm, clock running
  localparam pms_supply_s PMS_RUN_SUP = 7'h0F;

  function automatic pms_supply_s pms_decode(input logic [31:0] w);
    pms_supply_s s;
    s.clk_gate     = w[PMS_F_GATE];
    s.analogue_pfm = w[PMS_F_APFM];
    s.core_pfm     = w[PMS_F_CPFM];
    s.io_en        = w[PMS_F_IO];
    s.pll_en       = w[PMS_F_PLL];
    s.analogue_en  = w[PMS_F_AEN];
    s.core_en      = w[PMS_F_CEN];
    return s;
  endfunction : pms_decode

  function automatic logic pms_all_good(input pms_supply_s s, input pms_good_s g);
    return (!s.io_en || g.io) && (!s.pll_en || g.pll) &&
           (!s.analogue_en || g.analogue) && (!s.core_en || g.core);
  endfunction : pms_all_good
endpackage : pms_pkg

/* File: src/pms_dwell_timer.sv */
// minimum dwell timer: 2**n cycles of the running clock
`timescale 1ns/1ns
`default_nettype none
module pms_dwell_timer
  import pms_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [4:0] log2_n,
  output logic            done
);
  typedef struct packed {
    logic [31:0] cnt;
    logic [31:0] limit;
    logic        done;
  } pms_dwell_s;
  pms_dwell_s q, d;

  // counts on whatever clock drives clk, so a slow sleep clock stretches it
  always_comb begin
    d = q;
    if (start) begin
      d.cnt   = 32'h0;
      d.limit = (32'h1 << log2_n) - 32'h1;
      d.done  = 1'b0;
    end else if (!q.done) begin
      if (q.cnt == q.limit) d.done = 1'b1;
      else d.cnt = q.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) q <= '0;
    else q <= d;
  end
  assign done = q.done;

  AST_DWELL_FULL: assert property (@(posedge clk) disable iff (rst)
    $rose(q.done) |-> q.cnt == q.limit && q.limit == (32'h1 << $past(log2_n, 1)) - 32'h1 || $past(start))
    else $error("dwell ended before its count");
endmodule : pms_dwell_timer
`default_nettype wire

/* File: src/pms_top.sv */
// power mode sequencer: registers, sleep/wake state machine, supply outputs
//Contract
//- control bit 9 sets usb power-up enable
//- control bit 8 sets usb power-down enable
//- bit 7 picks power-on levels on wake
//- bit 6 re-applies run word, self-clears
//- bit 5 selects full 64-bit time compare
//- bit 4 enables wake on timer match
//- bit 2 enables pin wake, bit 3 level
//- bit 1 starts sleep, only in run
//- bit 0 sleep clock select, rest only
//- low wake word used only when asleep
//- high wake word ignored unless 64-bit
//- rest leaves after dwell only on wake
//- dwell counted on currently running clock
//- dwell field 20:16 gives 2**n cycles
//- first rise waits for enabled supplies good
//- state word bit 14 gates tile clock
//- bits 9/8 choose switcher pwm or pfm
//- bits 5,4,1,0 enable the four supplies
`timescale 1ns/1ns
`default_nettype none
module pms_top
  import pms_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire pms_req_s    req,
  output logic [31:0]      rdata,
  output logic             rvalid,
  input  wire logic [31:0] run_word,
  input  wire logic [31:0] rise2_word,
  input  wire logic [31:0] desc1_word,
  input  wire logic [31:0] desc2_word,
  input  wire logic [63:0] rtc_count,
  input  wire logic        wake_pin,
  input  wire pms_good_s   supply_good,
  output pms_supply_s      supply,
  output logic             usb_power_up_en,
  output logic             usb_power_down_en,
  output logic             use_por_levels,
  output logic             sleep_clk_default,
  output pms_state_e       seq_state
);
  typedef struct packed {
    pms_state_e  st;
    logic [31:0] ctrl;
    logic        sleep_req;
    logic        reapply;
    logic [31:0] wk_lo;
    logic [31:0] wk_hi;
    logic [31:0] rest;
    logic [31:0] rise1;
    logic        pin_s1;
    logic        pin_s2;
    pms_good_s   good_s1;
    pms_good_s   good_s2;
    logic        start;
    logic [4:0]  dwell_n;
    pms_supply_s sup;
    logic        por_out;
    logic        clk_def;
    logic [31:0] rdata;
    logic        rvalid;
  } pms_core_s;

  pms_core_s   q, d;
  logic        dwell_done;
  logic        tmr_hit;
  logic        pin_hit;
  logic        wake_any;
  logic        dwell_ok;
  logic        good_ok;
  pms_state_e  nxt;
  logic [31:0] nxt_word;

  pms_dwell_timer u_dwell (
    .clk    (clk),
    .rst    (rst),
    .start  (q.start),
    .log2_n (q.dwell_n),
    .done   (dwell_done)
  );

  // the compare only runs while asleep, so a match while run_state is not remembered
  pms_wake_cmp u_cmp (
    .clk       (clk),
    .rst       (rst),
    .enable    (q.ctrl[PMS_B_TMR_EN] && q.st == PMS_REST),
    .wide      (q.ctrl[PMS_B_WIDE]),
    .rtc_count (rtc_count),
    .wake_time ({q.wk_hi, q.wk_lo}),
    .hit       (tmr_hit)
  );

  always_comb begin
    pin_hit  = q.ctrl[PMS_B_PIN_EN] && (q.pin_s2 == q.ctrl[PMS_B_PIN_LVL]);
    wake_any = tmr_hit || pin_hit;
    // a done left over from the previous state is masked until the reload
    dwell_ok = dwell_done && !q.start;
    good_ok  = pms_all_good(q.sup, q.good_s2);
    nxt      = q.st;
    unique case (q.st)
      PMS_RUN:   if (q.sleep_req) nxt = PMS_DESC1;
      PMS_DESC1: if (dwell_ok) nxt = PMS_DESC2;
      PMS_DESC2: if (dwell_ok) nxt = PMS_REST;
      PMS_REST:  if (dwell_ok && wake_any) nxt = PMS_RISE1;
      PMS_RISE1: if (dwell_ok && good_ok) nxt = PMS_RISE2;
      PMS_RISE2: if (dwell_ok && good_ok) nxt = PMS_RUN;
      default:   nxt = PMS_RUN;
    endcase
    unique case (nxt)
      PMS_DESC1: nxt_word = desc1_word;
      PMS_DESC2: nxt_word = desc2_word;
      PMS_REST:  nxt_word = q.rest;
      PMS_RISE1: nxt_word = q.rise1;
      PMS_RISE2: nxt_word = rise2_word;
      default:   nxt_word = run_word;
    endcase
  end

  always_comb begin
    d         = q;
    d.rvalid  = 1'b0;
    d.reapply = 1'b0;
    d.start   = 1'b0;
    d.pin_s1  = wake_pin;
    d.pin_s2  = q.pin_s1;
    d.good_s1 = supply_good;
    d.good_s2 = q.good_s1;
    if (nxt != q.st) begin
      d.st      = nxt;
      d.start   = 1'b1;
      d.dwell_n = nxt_word[PMS_F_DWELL +: 5];
      d.sup     = pms_decode(nxt_word);
      if (q.st == PMS_RUN) d.sleep_req = 1'b0;
      if (q.st == PMS_REST) d.por_out = q.ctrl[PMS_B_POR_LVL];
    end else if (q.st == PMS_RUN && q.reapply) begin
      d.sup = pms_decode(run_word);
    end
    // register writes come after the sequencer so a fresh sleep request is kept
    if (req.wr) begin
      unique case (req.addr)
        PMS_OFF_CTRL: begin
          d.ctrl    = req.wdata & PMS_CTRL_WMASK;
          d.reapply = req.wdata[PMS_B_REAPPLY];
          if (req.wdata[PMS_B_SLEEP] && q.st == PMS_RUN) d.sleep_req = 1'b1;
        end
        PMS_OFF_WK_LO: d.wk_lo = req.wdata;
        PMS_OFF_WK_HI: d.wk_hi = req.wdata;
        PMS_OFF_REST:  d.rest  = (req.wdata & PMS_WORD_WMASK) | (q.rest & ~PMS_WORD_WMASK);
        PMS_OFF_RISE1: d.rise1 = (req.wdata & PMS_WORD_WMASK) | (q.rise1 & ~PMS_WORD_WMASK);
        default: ;
      endcase
    end
    // outside rest the sleep clock choice has no effect
    d.clk_def = (d.st == PMS_REST) ? d.ctrl[PMS_B_CLK_DEF] : 1'b1;
    if (req.rd) begin
      d.rvalid = 1'b1;
      unique case (req.addr)
        PMS_OFF_CTRL:  d.rdata = q.ctrl | {30'h0, q.sleep_req, 1'b0};
        PMS_OFF_WK_LO: d.rdata = q.wk_lo;
        PMS_OFF_WK_HI: d.rdata = q.wk_hi;
        PMS_OFF_REST:  d.rdata = q.rest;
        PMS_OFF_RISE1: d.rdata = q.rise1;
        default:       d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q         <= '0;
      q.st      <= PMS_RUN;
      q.ctrl    <= PMS_CTRL_RESET;
      q.wk_lo   <= PMS_WAKE_RESET;
      q.wk_hi   <= PMS_WAKE_RESET;
      q.rest    <= PMS_REST_RESET;
      q.rise1   <= PMS_RISE1_RESET;
      q.sup     <= PMS_RUN_SUP;
      q.clk_def <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign rdata             = q.rdata;
  assign rvalid            = q.rvalid;
  assign supply            = q.sup;
  assign usb_power_up_en   = q.ctrl[PMS_B_USB_UP];
  assign usb_power_down_en = q.ctrl[PMS_B_USB_DOWN];
  assign use_por_levels    = q.por_out;
  assign sleep_clk_default = q.clk_def;
  assign seq_state         = q.st;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic ctrl_wr;
  assign ctrl_wr = req.wr && req.addr == PMS_OFF_CTRL;

  sequence s_leave_rest;
    q.st == PMS_REST ##1 q.st == PMS_RISE1;
  endsequence
  sequence s_leave_rise1;
    q.st == PMS_RISE1 ##1 q.st == PMS_RISE2;
  endsequence
  sequence s_sleep_ask;
    ctrl_wr && req.wdata[PMS_B_SLEEP] && q.st == PMS_RUN ##1 q.sleep_req;
  endsequence
  sequence s_leave_desc2;
    q.st == PMS_DESC2 ##1 q.st != PMS_DESC2;
  endsequence
  sequence s_leave_rise2;
    q.st == PMS_RISE2 ##1 q.st != PMS_RISE2;
  endsequence
  sequence s_leave_run;
    q.st == PMS_RUN ##1 q.st != PMS_RUN;
  endsequence

  AST_USB_UP: assert property (
    ctrl_wr |=> usb_power_up_en == $past(req.wdata[PMS_B_USB_UP]))
    else $error("usb power-up enable not taken from write");
  AST_USB_DOWN: assert property (
    ctrl_wr |=> usb_power_down_en == $past(req.wdata[PMS_B_USB_DOWN]))
    else $error("usb power-down enable not taken from write");
  AST_POR_LEVELS: assert property (
    s_leave_rest |-> use_por_levels == $past(q.ctrl[PMS_B_POR_LVL]))
    else $error("level source not latched on wake");
  AST_REAPPLY: assert property (
    ctrl_wr && req.wdata[PMS_B_REAPPLY] && q.st == PMS_RUN && !q.sleep_req
    |=> ##1 supply == pms_decode($past(run_word)) && !q.reapply)
    else $error("run word not re-applied");
  AST_SLEEP_ONLY_RUN: assert property (
    ctrl_wr && q.st != PMS_RUN && !q.sleep_req |=> !q.sleep_req)
    else $error("sleep request taken outside run");
  AST_SLEEP_START: assert property (
    s_sleep_ask |=> q.st == PMS_DESC1 && !q.sleep_req && q.start)
    else $error("sleep sequence did not start");
  AST_REST_WAKE: assert property (
    s_leave_rest |-> $past(wake_any) && $past(dwell_done))
    else $error("rest left without wake or dwell");
  AST_PIN_WAKE: assert property (
    q.st == PMS_REST && dwell_ok && q.ctrl[PMS_B_PIN_EN] &&
    q.pin_s2 == q.ctrl[PMS_B_PIN_LVL] |=> q.st == PMS_RISE1)
    else $error("pin wake ignored");
  AST_RISE1_GOOD: assert property (
    s_leave_rise1 |-> $past(good_ok) && $past(dwell_done))
    else $error("first rise left with a supply not good");
  AST_SLEEP_CLK: assert property (
    q.st != PMS_REST |-> sleep_clk_default)
    else $error("sleep clock select acted outside rest");
  AST_APPLY_WORD: assert property (
    q.start && q.st == PMS_REST |-> supply == pms_decode($past(q.rest)))
    else $error("rest supplies not applied on entry");
  AST_ORDER: assert property (
    q.st == PMS_DESC1 ##1 q.st != PMS_DESC1 |-> q.st == PMS_DESC2)
    else $error("state order broken after first descent");
  AST_ORDER_DESC2: assert property (
    s_leave_desc2 |-> q.st == PMS_REST)
    else $error("state order broken after second descent");
  AST_ORDER_RISE2: assert property (
    s_leave_rise2 |-> q.st == PMS_RUN)
    else $error("state order broken after second rise");
  AST_ORDER_RUN: assert property (
    s_leave_run |-> q.st == PMS_DESC1 && $past(q.sleep_req))
    else $error("run left without a sleep request");

  // every hold below must keep the state until its own leave condition is met
  AST_RUN_HOLD: assert property (
    q.st == PMS_RUN && !q.sleep_req |=> q.st == PMS_RUN)
    else $error("run left with no sleep request");
  AST_SLEEP_CLEAR: assert property (
    q.sleep_req && q.st == PMS_RUN && !ctrl_wr |=> !q.sleep_req && q.st == PMS_DESC1)
    else $error("sleep request did not clear itself");
  AST_DESC1_DWELL: assert property (
    q.st == PMS_DESC1 && !dwell_ok |=> q.st == PMS_DESC1)
    else $error("first descent left before its dwell");
  AST_DESC2_DWELL: assert property (
    q.st == PMS_DESC2 && !dwell_ok |=> q.st == PMS_DESC2)
    else $error("second descent left before its dwell");
  AST_REST_EARLY: assert property (
    q.st == PMS_REST && !dwell_ok |=> q.st == PMS_REST)
    else $error("rest left before its dwell");
  AST_REST_NO_WAKE: assert property (
    q.st == PMS_REST && !wake_any |=> q.st == PMS_REST)
    else $error("rest left with no wake condition");
  AST_TMR_WAKE: assert property (
    q.st == PMS_REST && dwell_ok && tmr_hit |=> q.st == PMS_RISE1)
    else $error("timer wake ignored");
  AST_PIN_OFF: assert property (
    q.st == PMS_REST && !q.ctrl[PMS_B_PIN_EN] && !tmr_hit |=> q.st == PMS_REST)
    else $error("pin wake taken while disabled");
  AST_PIN_LEVEL: assert property (
    q.st == PMS_REST && q.pin_s2 != q.ctrl[PMS_B_PIN_LVL] && !tmr_hit |=> q.st == PMS_REST)
    else $error("pin wake taken at the wrong level");
  AST_RISE1_BAD: assert property (
    q.st == PMS_RISE1 && !good_ok |=> q.st == PMS_RISE1)
    else $error("first rise left with a supply not good");
  AST_RISE1_EARLY: assert property (
    q.st == PMS_RISE1 && !dwell_ok |=> q.st == PMS_RISE1)
    else $error("first rise left before its dwell");
  AST_RISE2_EARLY: assert property (
    q.st == PMS_RISE2 && !dwell_ok |=> q.st == PMS_RISE2)
    else $error("second rise left before its dwell");

  // supplies move only on a state change or a re-apply
  AST_REAPPLY_CLEAR: assert property (
    q.reapply && !ctrl_wr |=> !q.reapply)
    else $error("re-apply did not clear itself");
  AST_SUP_STEADY: assert property (
    $stable(q.st) && !$past(q.reapply) |-> $stable(supply))
    else $error("supplies changed inside a state");
  AST_SUP_RISE1: assert property (
    q.start && q.st == PMS_RISE1 |-> supply == pms_decode($past(q.rise1)))
    else $error("first rise supplies not applied on entry");
  AST_SUP_DESC1: assert property (
    q.start && q.st == PMS_DESC1 |-> supply == pms_decode($past(desc1_word)))
    else $error("first descent supplies not applied on entry");
  AST_CLK_REST: assert property (
    q.st == PMS_REST |-> sleep_clk_default == q.ctrl[PMS_B_CLK_DEF])
    else $error("sleep clock select not applied in rest");
  AST_POR_HOLD: assert property (
    $changed(use_por_levels) |-> $past(q.st) == PMS_REST)
    else $error("level source changed outside a wake");
  AST_USB_HOLD: assert property (
    !ctrl_wr |=> $stable(usb_power_up_en) && $stable(usb_power_down_en))
    else $error("usb enables changed without a write");

  // register port: stored bits, read-only bits and the self-clearing bits
  AST_WK_LO_WR: assert property (
    req.wr && req.addr == PMS_OFF_WK_LO |=> q.wk_lo == $past(req.wdata))
    else $error("low wake word not written");
  AST_WK_HI_WR: assert property (
    req.wr && req.addr == PMS_OFF_WK_HI |=> q.wk_hi == $past(req.wdata))
    else $error("high wake word not written");
  AST_REST_RO: assert property (
    $stable(q.rest & ~PMS_WORD_WMASK))
    else $error("read-only bits of the rest word changed");
  AST_RISE1_RO: assert property (
    $stable(q.rise1 & ~PMS_WORD_WMASK))
    else $error("read-only bits of the first rise word changed");
  AST_CTRL_RO: assert property (
    (q.ctrl & ~PMS_CTRL_WMASK) == 32'h0000_0000)
    else $error("control word stored a bit it must not keep");
  AST_CTRL_READ: assert property (
    req.rd && req.addr == PMS_OFF_CTRL |=> rvalid && rdata[PMS_B_SLEEP] == $past(q.sleep_req) &&
    !rdata[PMS_B_REAPPLY])
    else $error("control read shows wrong self-clearing bits");
endmodule : pms_top
`default_nettype wire

/* File: src/pms_wake_cmp.sv */
// wake-time compare against the real-time counter
`timescale 1ns/1ns
`default_nettype none
module pms_wake_cmp
  import pms_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        enable,
  input  wire logic        wide,
  input  wire logic [63:0] rtc_count,
  input  wire logic [63:0] wake_time,
  output logic             hit
);
  typedef struct packed {
    logic hit;
  } pms_cmp_s;
  pms_cmp_s q, d;
  logic lo_eq;
  logic hi_eq;

  // equality, not >=: a wake time already passed waits for the counter to wrap
  always_comb begin
    lo_eq = rtc_count[31:0] == wake_time[31:0];
    hi_eq = rtc_count[63:32] == wake_time[63:32];
    d.hit = enable && lo_eq && (!wide || hi_eq);
  end

  always_ff @(posedge clk) begin
    if (rst) q <= '0;
    else q <= d;
  end
  assign hit = q.hit;

  AST_CMP_NARROW: assert property (@(posedge clk) disable iff (rst)
    enable && !wide && lo_eq |=> hit)
    else $error("low word match missed in 32-bit mode");
  AST_CMP_GATED: assert property (@(posedge clk) disable iff (rst)
    hit |-> $past(enable) && $past(lo_eq))
    else $error("timer wake without enable or match");
endmodule : pms_wake_cmp
`default_nettype wire

/* File: testbench/pms_partner.sv */
// far-side model: supply regulators with power-good flags and a free-running real-time counter
`timescale 1ns/1ns
`default_nettype none
module pms_partner
  import pms_pkg::*;
#(
  parameter int LAG = 4
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire pms_supply_s supply,
  input  wire logic        hold_bad,
  output pms_good_s        good,
  output logic [63:0]      rtc_count
);
  logic [3:0] en_q;
  logic [7:0] age_q;
  logic [3:0] en_now;

  assign en_now = {supply.io_en, supply.pll_en, supply.analogue_en, supply.core_en};

  // a supply reports good only some cycles after its enable settles; hold_bad models a slow regulator
  always @(posedge clk) begin
    rtc_count <= rst ? 64'h0 : rtc_count + 64'h1;
    en_q      <= rst ? 4'h0 : en_now;
    age_q     <= (rst || en_q != en_now) ? 8'h00 : ((age_q == 8'hFF) ? age_q : age_q + 8'h01);
  end

  // disabled supplies read as not good rather than keeping a stale level
  assign good = (age_q >= LAG && !hold_bad) ? pms_good_s'(en_q) : pms_good_s'(4'h0);
endmodule : pms_partner
`default_nettype wire

/* File: testbench/power_mode_sequencer_tb_top.sv */
// self-checking testbench of the power mode sequencer
`timescale 1ns/1ns
`default_nettype none
module power_mode_sequencer_tb_top;
  import pms_pkg::*;
  logic        clk;
  logic        rst;
  pms_req_s    req;
  logic [31:0] rdata;
  logic        rvalid;
  logic [31:0] run_word, rise2_word, desc1_word, desc2_word;
  logic [63:0] rtc_count;
  logic        wake_pin, hold_bad, usb_up, usb_down, por_lvl, clk_def;
  pms_good_s   good;
  pms_supply_s supply;
  pms_state_e  seq_state, prev_s;
  int          err_count, n_compared, cycles, cyc, n, lv;
  logic [31:0] ctrl_m, rest_m, rise1_m, v, pw;
  logic [6:0]  exp_run;
  logic        mon_on;

  pms_top dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid), .run_word(run_word),
    .rise2_word(rise2_word), .desc1_word(desc1_word), .desc2_word(desc2_word), .rtc_count(rtc_count),
    .wake_pin(wake_pin), .supply_good(good), .supply(supply), .usb_power_up_en(usb_up),
    .usb_power_down_en(usb_down), .use_por_levels(por_lvl), .sleep_clk_default(clk_def), .seq_state(seq_state));
  pms_partner far (.clk(clk), .rst(rst), .supply(supply), .hold_bad(hold_bad), .good(good), .rtc_count(rtc_count));

  always #4 clk = ~clk;

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk);
    req.rd   = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    chk(rvalid, 1);
    chk(rdata, e);
  endtask : rd

  task automatic wait_st(input pms_state_e s, input int lim);
    for (int i = 0; i < lim && seq_state !== s; i++) @(negedge clk);
    chk(seq_state, s);
  endtask : wait_st

  function automatic logic [6:0] exp_sup(input logic [31:0] w);
    return {w[14], w[9], w[8], w[5], w[4], w[1], w[0]};
  endfunction : exp_sup

  function automatic logic [31:0] word_of(input pms_state_e s);
    case (s)
      PMS_DESC1: return desc1_word;
      PMS_DESC2: return desc2_word;
      PMS_REST:  return rest_m;
      PMS_RISE1: return rise1_m;
      default:   return rise2_word;
    endcase
  endfunction : word_of

  // new state words with short dwells; rise1 always enables the io supply so a stall is visible
  task automatic prep();
    desc1_word = ($urandom & 32'h4331) | (($urandom % 3) << 16);
    desc2_word = ($urandom & 32'h4331) | (($urandom % 3) << 16);
    rise2_word = ($urandom & 32'h4331) | (($urandom % 3) << 16);
    n = $urandom % 4;
    rest_m = ($urandom & 32'h4331) | (n << 16);
    wr(PMS_OFF_REST, rest_m);
    rise1_m = ($urandom & 32'h4331) | 32'h0001_0020;
    wr(PMS_OFF_RISE1, rise1_m);
  endtask : prep

  // reference model of the sequencer, checked every cycle
  always @(negedge clk) begin
    if (!rst) begin
      if (seq_state !== prev_s) begin
        if (prev_s != PMS_RUN) begin
          pw = word_of(prev_s);
          chk(cyc >= (1 << pw[20:16]), 1);
          if (prev_s inside {PMS_DESC1, PMS_DESC2}) chk(cyc <= (1 << pw[20:16]) + 1, 1);
        end
        chk(seq_state, (prev_s == PMS_RISE2) ? PMS_RUN : pms_state_e'(prev_s + 3'd1));
        prev_s = seq_state;
        cyc    = 0;
      end else begin
        cyc++;
      end
      if (mon_on) chk(supply, (seq_state == PMS_RUN) ? exp_run : exp_sup(word_of(seq_state)));
      chk(clk_def, (seq_state == PMS_REST) ? ctrl_m[0] : 1'b1);
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    clk = 0; rst = 1; req = '0; wake_pin = 0; hold_bad = 0; mon_on = 1; prev_s = PMS_RUN;
    err_count = 0; n_compared = 0; cycles = 0; cyc = 0;
    exp_run = 7'h0F; ctrl_m = PMS_CTRL_RESET; rest_m = PMS_REST_RESET; rise1_m = PMS_RISE1_RESET;
    void'($urandom(40));
    run_word = ($urandom & 32'h4331) | 32'h2;
    desc1_word = 0; desc2_word = 0; rise2_word = 0;
    repeat (2) @(negedge clk);
    rst = 0;
    rd(PMS_OFF_CTRL, 32'h8);
    rd(PMS_OFF_WK_LO, 0);
    rd(PMS_OFF_WK_HI, 0);
    rd(PMS_OFF_REST, 32'h0010_0000);
    rd(PMS_OFF_RISE1, 32'h0010_0020);
    rd(8'h14, 0);
    v = $urandom;
    wr(PMS_OFF_WK_LO, v);
    rd(PMS_OFF_WK_LO, v);
    v = $urandom;
    wr(PMS_OFF_WK_HI, v);
    rd(PMS_OFF_WK_HI, v);
    v = $urandom & ~32'h42;
    wr(PMS_OFF_CTRL, v);
    ctrl_m = v & 32'h3BD;
    rd(PMS_OFF_CTRL, ctrl_m);
    chk(usb_up, v[9]);
    chk(usb_down, v[8]);
    v = $urandom;
    wr(PMS_OFF_REST, v);
    rest_m = v & 32'h001F_4331;
    rd(PMS_OFF_REST, rest_m);
    // reapply changes the run supplies two cycles after the write, so the per-cycle check pauses
    mon_on = 0;
    wr(PMS_OFF_CTRL, ctrl_m | 32'h40);
    repeat (3) @(negedge clk);
    chk(supply, exp_sup(run_word));
    exp_run = exp_sup(run_word);
    mon_on = 1;
    rd(PMS_OFF_CTRL, ctrl_m);
    // pin wake at both levels, with a slow first rise
    for (lv = 1; lv >= 0; lv--) begin
      prep();
      wake_pin = !lv;
      hold_bad = 1;
      ctrl_m = 32'h4 | (lv << 3) | (lv << 7) | ($urandom & 1);
      wr(PMS_OFF_CTRL, ctrl_m);
      wr(PMS_OFF_CTRL, ctrl_m | 32'h2);
      wait_st(PMS_REST, 40);
      wr(PMS_OFF_CTRL, ctrl_m | 32'h2);
      repeat ((2 << n) + 8) @(negedge clk);
      chk(seq_state, PMS_REST);
      wake_pin = lv;
      wait_st(PMS_RISE1, 6);
      repeat (30) @(negedge clk);
      chk(seq_state, PMS_RISE1);
      hold_bad = 0;
      wait_st(PMS_RUN, 60);
      chk(por_lvl, lv);
    end
    // timer wake: high word ignored when narrow, then honoured when wide
    prep();
    wr(PMS_OFF_WK_HI, 32'h1);
    wr(PMS_OFF_WK_LO, rtc_count[31:0] + 32'd200);
    v = rtc_count[31:0] + 32'd200;
    ctrl_m = 32'h18;
    wr(PMS_OFF_CTRL, ctrl_m);
    wr(PMS_OFF_CTRL, ctrl_m | 32'h2);
    wait_st(PMS_RISE1, 400);
    chk(rtc_count[31:0] >= v, 1);
    wait_st(PMS_RUN, 60);
    prep();
    wr(PMS_OFF_WK_LO, rtc_count[31:0] + 32'd100);
    ctrl_m = 32'h38;
    wr(PMS_OFF_CTRL, ctrl_m);
    wr(PMS_OFF_CTRL, ctrl_m | 32'h2);
    wait_st(PMS_REST, 40);
    repeat (300) @(negedge clk);
    chk(seq_state, PMS_REST);
    wr(PMS_OFF_WK_HI, rtc_count[63:32]);
    wr(PMS_OFF_WK_LO, rtc_count[31:0] + 32'd50);
    wait_st(PMS_RISE1, 100);
    wait_st(PMS_RUN, 60);
    wrap_up();
  end
endmodule : power_mode_sequencer_tb_top
`default_nettype wire
